/* File: bench/sbm_ctrl_model.sv */
// controller-side model: strobe master on the register port
`timescale 1ns/10ps
module sbm_ctrl_model
	import sbm_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic [SBM_DW-1:0] rdata_i,
	output logic      [SBM_AW-1:0] addr_o,
	output logic      [SBM_DW-1:0] wdata_o,
	output logic                   wr_o,
	output logic                   rd_o
);
	initial begin
		addr_o  = '0;
		wdata_o = '0;
		wr_o    = 1'b0;
		rd_o    = 1'b0;
	end

	// ------------------------------------------------------------
	// bus cycles
	// ------------------------------------------------------------
	// idle address and data show the inverse, never a stale copy
	task automatic bus_write(input logic [SBM_AW-1:0] a,
		input logic [SBM_DW-1:0] d);
		@(posedge clk_i);
		addr_o  <= a;
		wdata_o <= d;
		wr_o    <= 1'b1;
		@(posedge clk_i);
		wr_o    <= 1'b0;
		addr_o  <= ~a;
		wdata_o <= ~d;
	endtask

	task automatic bus_read(input logic [SBM_AW-1:0] a,
		output logic [SBM_DW-1:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		@(posedge clk_i);
		rd_o   <= 1'b0;
		addr_o <= ~a;
		#1;
		d = rdata_i;
	endtask
endmodule

/* File: bench/tb_top.sv */
// self-checking bench for the bus-mapped terminal i/o
`timescale 1ns/10ps
module tb_top
	import sbm_pkg::*;
;
	logic              clk_i;
	logic              resetn_i;
	logic              ce_i;
	logic [SBM_AW-1:0] addr;
	logic [SBM_DW-1:0] wdata;
	logic              wr;
	logic              rd;
	logic [SBM_DW-1:0] rdata;
	logic              irq;
	logic [4:0]        din;
	logic              estop;
	logic              cut;
	logic              idx;
	logic [31:0]       pos;
	logic [15:0]       ain_a;
	logic [15:0]       ain_b;
	logic [15:0]       aout;
	logic [3:0]        dout;
	logic              tq;
	logic              es;
	logic [31:0]       v;
	logic [31:0]       r;
	int                seed;
	int                fail_count;
	int                samples_checked;
	int                an_q[$] = '{-10000, 0, 10000, 12000, -15000, 1};

	sbm_ctrl_model u_ctrl (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd));

	sbm_io DUT (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .irq_o(irq), .fast_input_a_i(din[0]),
		.fast_input_b_i(din[1]), .general_input_c_i(din[2]),
		.general_input_d_i(din[3]), .general_input_e_i(din[4]),
		.estop_pin_i(estop), .torque_cutoff_i(cut), .index_pulse_i(idx),
		.position_i(pos), .analog_in_a_i(ain_a), .analog_in_b_i(ain_b),
		.analog_out_a_o(aout), .bus_output_a_o(dout[0]),
		.bus_output_b_o(dout[1]), .bus_output_c_o(dout[2]),
		.brake_gate_output_o(dout[3]), .torque_enable_o(tq),
		.estop_stop_o(es));

	// ------------------------------------------------------------
	// reference model and compares
	// ------------------------------------------------------------
	function automatic int clampv(input int c);
		return (c > 10000) ? 10000 : ((c < -10000) ? -10000 : c);
	endfunction

	task automatic check_rd(input logic [31:0] got, exp, input string w);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: %s read %h expected %h", $time, w, got, exp);
		end
	endtask

	task automatic check_pin(input logic got, exp, input string w);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: %s is %b expected %b", $time, w, got, exp);
		end
	endtask

	task automatic check_an(input logic [15:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: analog out %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic conclude();
		if (fail_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// drive torque request, then check torque and brake after settling
	task automatic run_req(input logic exp);
		u_ctrl.bus_write(SBM_OFF_CTRL, 32'h0000_0001);
		tick(4);
		check_pin(tq, exp, "torque");
		check_pin(dout[3], exp, "brake");
	endtask

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	initial begin
		#100000;
		fail_count++;
		conclude();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'h5388dd56;
		resetn_i = 1'b0;
		ce_i = 1'b1;
		din = '0;
		estop = 1'b0;
		cut = 1'b0;
		idx = 1'b0;
		pos = '0;
		ain_a = '0;
		ain_b = '0;
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		tick(1);
		check_pin(tq, 1'b0, "torque at reset");
		for (int i = 0; i < 6; i++) begin
			v = $random(seed);
			@(posedge clk_i);
			din <= v[4:0];
			tick(4);
			u_ctrl.bus_read(SBM_OFF_DIN, r);
			check_rd(r & 32'h01F0_0000, {7'h00, v[4:0], 20'h0}, "din");
		end
		u_ctrl.bus_write(SBM_OFF_CFG, 32'h0000_0001);
		for (int k = 0; k < 16; k++) begin
			u_ctrl.bus_write(SBM_OFF_DOUT, 32'(k) << 16);
			tick(2);
			for (int b = 0; b < 4; b++)
				check_pin(dout[b], k[b], "dout");
			u_ctrl.bus_read(SBM_OFF_DOUT, r);
			check_rd(r & 32'h000F_0000, 32'(k) << 16, "dout word");
		end
		an_q.push_back($random(seed) % 10001);
		foreach (an_q[j]) begin
			@(posedge clk_i);
			ain_a <= 16'(an_q[j]);
			ain_b <= 16'(-an_q[j]);
			tick(3);
			u_ctrl.bus_read(SBM_OFF_AINA, r);
			check_rd(r, 32'(clampv(an_q[j])), "ain a");
			u_ctrl.bus_read(SBM_OFF_AINB, r);
			check_rd(r, 32'(clampv(-an_q[j])), "ain b");
			u_ctrl.bus_write(SBM_OFF_AOUT, {16'h0, 16'(an_q[j])});
			tick(2);
			check_an(aout, 16'(clampv(an_q[j])));
		end
		// probe a on fast input a; fast input b must not trigger it
		v = $random(seed);
		@(posedge clk_i);
		pos <= v;
		u_ctrl.bus_write(SBM_OFF_CFG, 32'h0000_0010);
		u_ctrl.bus_write(SBM_OFF_STAT, 32'h0000_000F);
		@(posedge clk_i);
		din[1] <= ~din[1];
		tick(6);
		u_ctrl.bus_read(SBM_OFF_STAT, r);
		check_rd(r & 32'hF, 32'h0, "no probe");
		@(posedge clk_i);
		din[0] <= ~din[0];
		tick(6);
		u_ctrl.bus_read(SBM_OFF_PRBA, r);
		check_rd(r, v, "probe a");
		u_ctrl.bus_read(SBM_OFF_STAT, r);
		check_rd(r & 32'hF, 32'h1, "status a");
		check_pin(irq, 1'b0, "irq masked");
		u_ctrl.bus_write(SBM_OFF_MASK, 32'h0000_000F);
		tick(1);
		check_pin(irq, 1'b1, "irq");
		u_ctrl.bus_write(SBM_OFF_STAT, 32'h0000_0001);
		tick(1);
		check_pin(irq, 1'b0, "irq cleared");
		// probe b on the index pulse
		v = $random(seed);
		@(posedge clk_i);
		pos <= v;
		u_ctrl.bus_write(SBM_OFF_CFG, 32'h0000_0028);
		@(posedge clk_i);
		idx <= 1'b1;
		tick(6);
		u_ctrl.bus_read(SBM_OFF_PRBB, r);
		check_rd(r, v, "probe b");
		u_ctrl.bus_read(SBM_OFF_STAT, r);
		check_rd(r & 32'hF, 32'h2, "status b");
		// torque, emergency stop and cutoff; brake follows torque
		u_ctrl.bus_write(SBM_OFF_CFG, 32'h0000_0000);
		u_ctrl.bus_write(SBM_OFF_STAT, 32'h0000_000F);
		run_req(1'b1);
		@(posedge clk_i);
		estop <= 1'b1;
		tick(6);
		check_pin(es, 1'b1, "estop");
		check_pin(tq, 1'b0, "torque estop");
		check_pin(irq, 1'b1, "irq estop");
		@(posedge clk_i);
		estop <= 1'b0;
		tick(6);
		check_pin(tq, 1'b0, "no restart");
		run_req(1'b1);
		// closed sense: an open pin means stop
		u_ctrl.bus_write(SBM_OFF_CFG, 32'h0000_0002);
		tick(5);
		check_pin(es, 1'b1, "estop closed");
		@(posedge clk_i);
		estop <= 1'b1;
		tick(4);
		check_pin(es, 1'b0, "estop healthy");
		run_req(1'b1);
		@(posedge clk_i);
		cut <= 1'b1;
		tick(6);
		check_pin(tq, 1'b0, "torque cutoff");
		u_ctrl.bus_read(SBM_OFF_STATE, r);
		check_rd(r & 32'h7, 32'h2, "state");
		u_ctrl.bus_read(SBM_OFF_STAT, r);
		check_rd(r & 32'h8, 32'h8, "status cutoff");
		run_req(1'b0);
		@(posedge clk_i);
		cut <= 1'b0;
		tick(6);
		check_pin(tq, 1'b0, "cutoff released");
		run_req(1'b1);
		// clock enable low: a write is ignored and outputs hold
		@(posedge clk_i);
		ce_i <= 1'b0;
		u_ctrl.bus_write(SBM_OFF_DOUT, 32'h0000_0000);
		tick(2);
		check_pin(dout[0], 1'b1, "frozen output");
		check_pin(tq, 1'b1, "frozen torque");
		@(posedge clk_i);
		ce_i <= 1'b1;
		tick(1);
		check_pin(dout[0], 1'b1, "output after enable");
		// unmapped place reads zero and ignores writes
		u_ctrl.bus_write(8'h3C, $random(seed));
		u_ctrl.bus_read(8'h3C, r);
		check_rd(r, 32'h0, "unmapped");
		conclude();
	end
endmodule

/* File: design/sbm_clamp.sv */
// saturating limiter for signed millivolt codes
`timescale 1ns/10ps
module sbm_clamp
	import sbm_pkg::*;
#(
	parameter int W = 16
) (
	input  wire logic [W-1:0] value_i,
	output wire logic [W-1:0] value_o
);

	// linear pass inside the window, saturate outside [R06]
	wire logic signed [W-1:0] val_s;
	wire logic signed [W-1:0] max_s;
	wire logic signed [W-1:0] min_s;
	wire logic                over_w;
	wire logic                under_w;

	assign val_s   = value_i;
	assign max_s   = W'(signed'(SBM_AN_MAX));
	assign min_s   = W'(signed'(SBM_AN_MIN));
	assign over_w  = val_s > max_s;
	assign under_w = val_s < min_s;
	assign value_o = over_w  ? max_s :
	                 under_w ? min_s : value_i;

endmodule

/* File: design/sbm_io.sv */
// terminal i/o of the servo drive mapped onto bus process words
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module sbm_io
	import sbm_pkg::*;
#(
	parameter int POS_W = 32
) (
	input  wire logic              clk_i,
	input  wire logic              resetn_i,
	input  wire logic              ce_i,
	input  wire logic [SBM_AW-1:0] addr_i,
	input  wire logic [SBM_DW-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [SBM_DW-1:0] rdata_o,
	output logic                   irq_o,
	input  wire logic              fast_input_a_i,
	input  wire logic              fast_input_b_i,
	input  wire logic              general_input_c_i,
	input  wire logic              general_input_d_i,
	input  wire logic              general_input_e_i,
	input  wire logic              estop_pin_i,
	input  wire logic              torque_cutoff_i,
	input  wire logic              index_pulse_i,
	input  wire logic [POS_W-1:0]  position_i,
	input  wire logic [SBM_AN_W-1:0] analog_in_a_i,
	input  wire logic [SBM_AN_W-1:0] analog_in_b_i,
	output logic      [SBM_AN_W-1:0] analog_out_a_o,
	output logic                   bus_output_a_o,
	output logic                   bus_output_b_o,
	output logic                   bus_output_c_o,
	output logic                   brake_gate_output_o,
	output logic                   torque_enable_o,
	output logic                   estop_stop_o
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [SBM_NSYNC-1:0] sync1_r;
	logic [SBM_NSYNC-1:0] sync2_r;
	logic [SBM_NSYNC-1:0] prev_r;
	wire  logic [SBM_NSYNC-1:0] raw_w;

	assign raw_w = {index_pulse_i, torque_cutoff_i, estop_pin_i,
	                general_input_e_i, general_input_d_i,
	                general_input_c_i, fast_input_b_i, fast_input_a_i};

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r  <= '0;
		end else if (ce_i) begin
			sync1_r <= raw_w;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	logic [SBM_NCFG-1:0]     cfg_r;
	logic [3:0]              dout_r;
	logic [SBM_NEV-1:0]      stat_r;
	logic [SBM_NEV-1:0]      mask_r;
	logic                    run_r;
	logic [SBM_AN_W-1:0]     ain_a_r;
	logic [SBM_AN_W-1:0]     ain_b_r;
	logic [SBM_AN_W-1:0]     aout_r;
	logic                    brake_r;
	logic                    torque_r;
	logic [POS_W-1:0]        latch_r [SBM_NPROBE];
	logic [SBM_DW-1:0]       rdata_r;

	wire logic wr_dout  = ce_i && wr_i && addr_i == SBM_OFF_DOUT;
	wire logic wr_cfg   = ce_i && wr_i && addr_i == SBM_OFF_CFG;
	wire logic wr_aout  = ce_i && wr_i && addr_i == SBM_OFF_AOUT;
	wire logic wr_stat  = ce_i && wr_i && addr_i == SBM_OFF_STAT;
	wire logic wr_mask  = ce_i && wr_i && addr_i == SBM_OFF_MASK;
	wire logic wr_ctrl  = ce_i && wr_i && addr_i == SBM_OFF_CTRL;

	// ----------------------------------------------------------------
	// safety inputs
	// ----------------------------------------------------------------
	wire logic estop_act;
	wire logic estop_prev;
	wire logic cut_act;
	wire logic cut_prev;

	// closed-contact sense inverts the pin, so a broken wire also stops
	assign estop_act  = sync2_r[SBM_SY_ESTOP] ^ cfg_r[SBM_CFG_ESNC]; // [R09]
	assign estop_prev = prev_r[SBM_SY_ESTOP]  ^ cfg_r[SBM_CFG_ESNC];
	assign cut_act    = sync2_r[SBM_SY_CUT];
	assign cut_prev   = prev_r[SBM_SY_CUT];

	// ----------------------------------------------------------------
	// probes
	// ----------------------------------------------------------------
	wire logic [SBM_NPROBE-1:0] probe_edge;
	genvar gi;
	generate
		for (gi = 0; gi < SBM_NPROBE; gi++) begin : g_probe
			wire logic src_idx = cfg_r[SBM_CFG_SRCA + gi];
			// probe gi triggers from fast input gi, or from the index pulse when its source bit is set
			wire logic trig_now = src_idx ? sync2_r[SBM_SY_INDEX]
			                              : sync2_r[gi]; // [R08]
			wire logic trig_old = src_idx ? prev_r[SBM_SY_INDEX]
			                              : prev_r[gi];
			assign probe_edge[gi] = cfg_r[SBM_CFG_ENA + gi] &&
			                        (trig_now ^ trig_old); // [R07]

			always_ff @(posedge clk_i) begin
				if (!resetn_i) begin
					latch_r[gi] <= '0;
				end else if (ce_i && probe_edge[gi]) begin
					latch_r[gi] <= position_i; // [R07]
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// events and interrupt
	// ----------------------------------------------------------------
	wire logic [SBM_NEV-1:0] ev_w;
	wire logic [SBM_NEV-1:0] stat_nxt;

	assign ev_w = {cut_act & ~cut_prev, estop_act & ~estop_prev,
	               probe_edge};
	// new event wins over a clearing write in the same cycle
	assign stat_nxt = (stat_r & ~(wr_stat ? wdata_i[SBM_NEV-1:0] : '0))
	                  | ev_w;
	assign irq_o    = |(stat_r & mask_r);

	// ----------------------------------------------------------------
	// analog scaling
	// ----------------------------------------------------------------
	wire logic [SBM_AN_W-1:0] ain_a_c;
	wire logic [SBM_AN_W-1:0] ain_b_c;
	wire logic [SBM_AN_W-1:0] aout_c;

	sbm_clamp #(.W(SBM_AN_W)) u_clamp_ain_a (
		.value_i (analog_in_a_i),
		.value_o (ain_a_c)
	);
	sbm_clamp #(.W(SBM_AN_W)) u_clamp_ain_b (
		.value_i (analog_in_b_i),
		.value_o (ain_b_c)
	);
	sbm_clamp #(.W(SBM_AN_W)) u_clamp_aout (
		.value_i (wdata_i[SBM_AN_W-1:0]),
		.value_o (aout_c)
	);

	// ----------------------------------------------------------------
	// torque, run request and brake
	// ----------------------------------------------------------------
	wire logic run_nxt;
	wire logic torque_nxt;
	wire logic brake_nxt;

	// safety clear beats a run write; restart needs a fresh request
	assign run_nxt    = (estop_act || cut_act) ? 1'b0 :
	                    wr_ctrl ? wdata_i[SBM_CTRL_RUN] : run_r; // [R09] [R10]
	assign torque_nxt = run_r && !estop_act && !cut_act; // [R10]
	assign brake_nxt  = cfg_r[SBM_CFG_BRKBUS] ? dout_r[3]
	                                          : torque_r; // [R03]

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cfg_r    <= SBM_CFG_RST;
			dout_r   <= SBM_DOUT_RST;
			mask_r   <= SBM_MASK_RST;
			stat_r   <= '0;
			run_r    <= 1'b0;
			torque_r <= 1'b0;
			brake_r  <= 1'b0;
			aout_r   <= '0;
			ain_a_r  <= '0;
			ain_b_r  <= '0;
		end else if (ce_i) begin
			if (wr_cfg)  cfg_r  <= wdata_i[SBM_NCFG-1:0];
			if (wr_dout) dout_r <= wdata_i[SBM_DOUT_MSB:SBM_DOUT_LSB]; // [R02]
			if (wr_mask) mask_r <= wdata_i[SBM_NEV-1:0];
			if (wr_aout) aout_r <= aout_c; // [R05] [R06]
			stat_r   <= stat_nxt;
			run_r    <= run_nxt;
			torque_r <= torque_nxt;
			brake_r  <= brake_nxt;
			ain_a_r  <= ain_a_c; // [R04]
			ain_b_r  <= ain_b_c; // [R04]
		end
	end

	assign bus_output_a_o      = dout_r[0]; // [R02]
	assign bus_output_b_o      = dout_r[1];
	assign bus_output_c_o      = dout_r[2];
	assign brake_gate_output_o = brake_r;
	assign torque_enable_o     = torque_r;
	assign estop_stop_o        = estop_act; // [R09]
	assign analog_out_a_o      = aout_r;

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	wire logic [SBM_DW-1:0] din_word;
	wire logic [SBM_DW-1:0] rd_mux;

	assign din_word = {{(SBM_DW-SBM_DIN_MSB-1){1'b0}},
	                   sync2_r[4:0], {SBM_DIN_LSB{1'b0}}}; // [R01]

	assign rd_mux =
	  (addr_i == SBM_OFF_DIN)   ? din_word :
	  (addr_i == SBM_OFF_DOUT)  ? {{(SBM_DW-SBM_DOUT_MSB-1){1'b0}},
	                               dout_r, {SBM_DOUT_LSB{1'b0}}} :
	  (addr_i == SBM_OFF_CFG)   ? {{(SBM_DW-SBM_NCFG){1'b0}}, cfg_r} :
	  (addr_i == SBM_OFF_AINA)  ? {{SBM_AN_W{ain_a_r[SBM_AN_W-1]}},
	                               ain_a_r} :
	  (addr_i == SBM_OFF_AINB)  ? {{SBM_AN_W{ain_b_r[SBM_AN_W-1]}},
	                               ain_b_r} :
	  (addr_i == SBM_OFF_AOUT)  ? {{SBM_AN_W{aout_r[SBM_AN_W-1]}},
	                               aout_r} :
	  (addr_i == SBM_OFF_PRBA)  ? SBM_DW'(latch_r[0]) :
	  (addr_i == SBM_OFF_PRBB)  ? SBM_DW'(latch_r[1]) :
	  (addr_i == SBM_OFF_STAT)  ? {{(SBM_DW-SBM_NEV){1'b0}}, stat_r} :
	  (addr_i == SBM_OFF_MASK)  ? {{(SBM_DW-SBM_NEV){1'b0}}, mask_r} :
	  (addr_i == SBM_OFF_STATE) ? {29'h0000_0000, torque_r, cut_act,
	                               estop_act} :
	  (addr_i == SBM_OFF_CTRL)  ? {31'h0000_0000, run_r} :
	                              32'h0000_0000;

	// data stands only in the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rdata_r <= '0;
		end else if (ce_i) begin
			rdata_r <= rd_i ? rd_mux : '0;
		end
	end
	assign rdata_o = rdata_r;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_din_map;
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && rd_i && addr_i == SBM_OFF_DIN |=>
			rdata_o[SBM_DIN_MSB:SBM_DIN_LSB] == $past(sync2_r[4:0]);
	endproperty
	a_din_map: assert property (p_din_map) // [R01]
		else $error("input word bits do not match inputs");

	property p_dout;
		@(posedge clk_i) disable iff (!resetn_i)
		wr_dout |=> bus_output_a_o == $past(wdata_i[16]) &&
			bus_output_b_o == $past(wdata_i[17]) &&
			bus_output_c_o == $past(wdata_i[18]);
	endproperty
	a_dout: assert property (p_dout) // [R02]
		else $error("bus outputs do not follow output word");

	// mode is judged in the cycle that loads the brake flop
	property p_brake;
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && !cfg_r[SBM_CFG_BRKBUS] |=>
			brake_gate_output_o == $past(torque_enable_o);
	endproperty
	a_brake: assert property (p_brake) // [R03]
		else $error("brake gate not tracking torque enable");

	property p_brake_bus;
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && cfg_r[SBM_CFG_BRKBUS] |=>
			brake_gate_output_o == $past(dout_r[3]);
	endproperty
	a_brake_bus: assert property (p_brake_bus) // [R03]
		else $error("brake gate not following output word in bus mode");

	property p_ain_range;
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && rd_i && addr_i == SBM_OFF_AINA |=>
			$signed(rdata_o) <= 32'sd10000 &&
			$signed(rdata_o) >= -32'sd10000;
	endproperty
	a_ain_range: assert property (p_ain_range) // [R04]
		else $error("analog input code out of range");

	property p_aout;
		@(posedge clk_i) disable iff (!resetn_i)
		wr_aout && $signed(wdata_i[15:0]) > 16'sd10000 |=>
			analog_out_a_o == SBM_AN_MAX;
	endproperty
	a_aout: assert property (p_aout) // [R06]
		else $error("analog output not clamped");

	property p_aout_low;
		@(posedge clk_i) disable iff (!resetn_i)
		wr_aout && $signed(wdata_i[15:0]) < -16'sd10000 |=>
			analog_out_a_o == SBM_AN_MIN;
	endproperty
	a_aout_low: assert property (p_aout_low) // [R06]
		else $error("analog output not clamped at low end");

	property p_aout_pass;
		@(posedge clk_i) disable iff (!resetn_i)
		wr_aout && $signed(wdata_i[15:0]) <= 16'sd10000 &&
			$signed(wdata_i[15:0]) >= -16'sd10000 |=>
			analog_out_a_o == $past(wdata_i[15:0]);
	endproperty
	a_aout_pass: assert property (p_aout_pass) // [R05]
		else $error("analog output code not passed through");

	property p_probe;
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && probe_edge[0] |=>
			latch_r[0] == $past(position_i) && stat_r[SBM_EV_PRBA];
	endproperty
	a_probe: assert property (p_probe) // [R07]
		else $error("probe did not latch position");

	property p_estop;
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && estop_act |=> !torque_enable_o && !run_r;
	endproperty
	a_estop: assert property (p_estop) // [R09]
		else $error("torque still on after emergency stop");

	property p_cut;
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && cut_act ##1 ce_i && !wr_ctrl |=> !torque_enable_o;
	endproperty
	a_cut: assert property (p_cut) // [R10]
		else $error("torque on during or after cutoff");

	property p_irq;
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && ev_w[SBM_EV_CUT] && mask_r[SBM_EV_CUT] && !wr_mask
			|=> irq_o;
	endproperty
	a_irq: assert property (p_irq)
		else $error("masked-in event gave no interrupt");

	c_probe_a: cover property (@(posedge clk_i) ce_i && probe_edge[0]);
	c_probe_b: cover property (@(posedge clk_i) ce_i && probe_edge[1]);
	c_estop:   cover property (@(posedge clk_i) ce_i && ev_w[SBM_EV_ESTOP]);
	c_restart: cover property (@(posedge clk_i)
		$fell(cut_act) ##[1:20] torque_enable_o);

endmodule

/* File: inc/sbm_pkg.sv */
// constants, offsets and field layout of the servo bus-mapped terminal i/o
//
// Notes on behaviour
// R01: live inputs a..e read as bits 20..24 of the input word, in order.
// R02: controller writes bits 16..18 of output word; outputs a..c follow them.
// R03: brake gate follows torque enable, or output-word bit 19 in bus mode.
// R04: analog inputs read signed, one count per millivolt, -10000..+10000.
// R05: analog output word signed, -10000 gives -10 V, +10000 gives +10 V.
// R06: linear one count per millivolt; codes beyond ten thousand are clamped.
// R07: two probes latch motor position on any change of chosen trigger.
// R08: probe a triggers from fast input a, probe b from fast input b.
// R09: triggered emergency stop stops the servo; sense open or closed.
// R10: torque cutoff removes torque, motor coasts, no restart without request.
package sbm_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int          SBM_AW        = 8;
	localparam int          SBM_DW        = 32;
	localparam int          SBM_AN_W      = 16;
	localparam int          SBM_NPROBE    = 2;
	localparam int          SBM_NSYNC     = 8;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  SBM_OFF_DIN   = 8'h00;
	localparam logic [7:0]  SBM_OFF_DOUT  = 8'h04;
	localparam logic [7:0]  SBM_OFF_CFG   = 8'h08;
	localparam logic [7:0]  SBM_OFF_AINA  = 8'h0C;
	localparam logic [7:0]  SBM_OFF_AINB  = 8'h10;
	localparam logic [7:0]  SBM_OFF_AOUT  = 8'h14;
	localparam logic [7:0]  SBM_OFF_PRBA  = 8'h18;
	localparam logic [7:0]  SBM_OFF_PRBB  = 8'h1C;
	localparam logic [7:0]  SBM_OFF_STAT  = 8'h20;
	localparam logic [7:0]  SBM_OFF_MASK  = 8'h24;
	localparam logic [7:0]  SBM_OFF_STATE = 8'h28;
	localparam logic [7:0]  SBM_OFF_CTRL  = 8'h2C;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int          SBM_DIN_LSB   = 20;
	localparam int          SBM_DIN_MSB   = 24;
	localparam int          SBM_DOUT_LSB  = 16;
	localparam int          SBM_DOUT_MSB  = 19;
	localparam int          SBM_DOUT_BRK  = 19;
	localparam int          SBM_CFG_BRKBUS = 0;
	localparam int          SBM_CFG_ESNC  = 1;
	localparam int          SBM_CFG_SRCA  = 2;
	localparam int          SBM_CFG_ENA   = 4;
	localparam int          SBM_CTRL_RUN  = 0;
	localparam int          SBM_EV_PRBA   = 0;
	localparam int          SBM_EV_ESTOP  = 2;
	localparam int          SBM_EV_CUT    = 3;
	localparam int          SBM_NEV       = 4;
	localparam int          SBM_ST_ESTOP  = 0;
	localparam int          SBM_ST_CUT    = 1;
	localparam int          SBM_ST_TQ     = 2;
	localparam int          SBM_NCFG      = 6;

	// sync vector layout: inputs a..e at 0..4
	localparam int          SBM_SY_ESTOP  = 5;
	localparam int          SBM_SY_CUT    = 6;
	localparam int          SBM_SY_INDEX  = 7;

	// ----------------------------------------------------------------
	// reset values and analog limits
	// ----------------------------------------------------------------
	localparam logic [5:0]  SBM_CFG_RST   = 6'h00;
	localparam logic [3:0]  SBM_DOUT_RST  = 4'h0;
	localparam logic [3:0]  SBM_MASK_RST  = 4'h0;
	localparam logic [15:0] SBM_AN_MAX    = 16'h2710;
	localparam logic [15:0] SBM_AN_MIN    = 16'hD8F0;

endpackage
